// file: core/glpu_consts.vh
// Purpose: constants for the general line port unit
// Assumes: APB byte addresses, 32 lines
// Notes: all offsets are word aligned
`ifndef GLPU_CONSTS_VH
`define GLPU_CONSTS_VH
`define GLPU_LINES 32
`define GLPU_AW 8
`define GLPU_PER 8'h00
`define GLPU_PDR 8'h04
`define GLPU_PSR 8'h08
`define GLPU_OER 8'h10
`define GLPU_ODR 8'h14
`define GLPU_OSR 8'h18
`define GLPU_IFER 8'h20
`define GLPU_IFDR 8'h24
`define GLPU_IFSR 8'h28
`define GLPU_SODR 8'h30
`define GLPU_CODR 8'h34
`define GLPU_ODSR 8'h38
`define GLPU_PDSR 8'h3c
`define GLPU_IER 8'h40
`define GLPU_IDR 8'h44
`define GLPU_IMR 8'h48
`define GLPU_ISR 8'h4c
`define GLPU_MDER 8'h50
`define GLPU_MDDR 8'h54
`define GLPU_MDSR 8'h58
`define GLPU_PUDR 8'h60
`define GLPU_PUER 8'h64
`define GLPU_PUSR 8'h68
`define GLPU_ASR 8'h70
`define GLPU_BSR 8'h74
`define GLPU_ABSR 8'h78
`define GLPU_ANER 8'h80
`define GLPU_ANDR 8'h84
`define GLPU_ANSR 8'h88
`define GLPU_OWER 8'ha0
`define GLPU_OWDR 8'ha4
`define GLPU_OWSR 8'ha8
`define GLPU_ONES 32'hffff_ffff
`define GLPU_ZERO 32'h0000_0000
`define GLPU_PERIPH_ID 8'h02
`endif

// file: core/glpu_line_in.v
// Purpose: per-line input synchroniser and one-period glitch filter
// Assumes: pad input is asynchronous to i_clk_sys
// Notes: filter needs two equal synchronised samples before accepting a level
`timescale 1ns/1ns
module glpu_line_in (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_pad,
  input wire i_filt_en,
  output reg o_level
);
  reg sync1_r;
  reg sync2_r;
  reg prev_r;
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
      o_level <= 1'b1;
    end else begin
      sync1_r <= i_pad;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      // a pulse shorter than a sample period never shows twice in a row
      if (!i_filt_en || (prev_r == sync2_r)) begin
        o_level <= sync2_r;
      end
    end
  end
endmodule

// file: core/glpu_top.v
// Purpose: general line port unit, 32 pad lines with APB register file
// Assumes: i_clk_sys is the system master clock, 100 MHz
// Notes: pads are split into in, out and output enable; pull-up is a pad control
// Function
// - one controller, 32 lines, every control a bit per line.
// - each line is port controlled or driven by peripheral A or B.
// - set and clear write addresses; writing one acts, zero leaves bit.
// - any level change on any line raises input-change interrupt.
// - per-line glitch filter removes pulses under one clock period.
// - multi-drive option makes line open drain: drive low only.
// - per-line pull-up enable under software control.
// - pin data status shows real pad level in every mode.
// - one write sets and clears outputs on several lines together.
// - after reset lines are port-controlled inputs with pull-ups on.
// - some lines release digital drive for analog converter inputs.
// - interrupt output goes to interrupt controller as peripheral 2.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "glpu_consts.vh"
module glpu_top (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire [31:0] i_pad_in,
  output wire [31:0] o_pad_out,
  output wire [31:0] o_pad_oe,
  output wire [31:0] o_pad_pullup_en,
  output wire [31:0] o_pad_analog_en,
  input wire [31:0] i_periph_a_out,
  input wire [31:0] i_periph_a_oe,
  input wire [31:0] i_periph_b_out,
  input wire [31:0] i_periph_b_oe,
  output wire [31:0] o_periph_in,
  output wire o_irq,
  output wire [7:0] o_irq_id
);
  // per-line state, one bit per line
  reg [31:0] port_en_r;
  reg [31:0] out_en_r;
  reg [31:0] filt_en_r;
  reg [31:0] out_data_r;
  reg [31:0] irq_mask_r;
  reg [31:0] irq_pend_r;
  reg [31:0] multi_drv_r;
  reg [31:0] pull_dis_r;
  reg [31:0] sel_b_r;
  reg [31:0] analog_r;
  reg [31:0] wr_en_r;
  reg [31:0] last_lvl_r;
  wire [31:0] level;
  wire [31:0] changed;
  wire [31:0] drv_val;
  wire [31:0] drv_oe;
  wire wr_acc;
  wire rd_acc;
  reg [31:0] rd_nxt;
  reg hit_nxt;

  // every line has its own synchroniser and filter
  genvar g;
  generate
    for (g = 0; g < `GLPU_LINES; g = g + 1) begin : g_line
      glpu_line_in u_in (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_pad(i_pad_in[g]),
        .i_filt_en(filt_en_r[g]),
        .o_level(level[g])
      );
      assign drv_val[g] = port_en_r[g] ? out_data_r[g] :
                          (sel_b_r[g] ? i_periph_b_out[g] : i_periph_a_out[g]);
      assign drv_oe[g] = port_en_r[g] ? out_en_r[g] :
                         (sel_b_r[g] ? i_periph_b_oe[g] : i_periph_a_oe[g]);
    end
  endgenerate

  // open drain: high becomes release; analog lines are never driven
  assign o_pad_out = drv_val & ~multi_drv_r;
  assign o_pad_oe = drv_oe & ~(multi_drv_r & drv_val) & ~analog_r;
  assign o_pad_pullup_en = ~pull_dis_r;
  assign o_pad_analog_en = analog_r;
  assign o_periph_in = level;

  assign changed = level ^ last_lvl_r;
  assign o_irq = |(irq_pend_r & irq_mask_r);
  assign o_irq_id = `GLPU_PERIPH_ID;

  // zero wait state slave
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign wr_acc = i_psel & i_penable & i_pwrite;
  assign rd_acc = i_psel & i_penable & ~i_pwrite;

  always @* begin
    rd_nxt = `GLPU_ZERO;
    hit_nxt = 1'b1;
    case (i_paddr)
      `GLPU_PSR: rd_nxt = port_en_r;
      `GLPU_OSR: rd_nxt = out_en_r;
      `GLPU_IFSR: rd_nxt = filt_en_r;
      `GLPU_ODSR: rd_nxt = out_data_r;
      `GLPU_PDSR: rd_nxt = level;
      `GLPU_IMR: rd_nxt = irq_mask_r;
      `GLPU_ISR: rd_nxt = irq_pend_r;
      `GLPU_MDSR: rd_nxt = multi_drv_r;
      `GLPU_PUSR: rd_nxt = pull_dis_r;
      `GLPU_ABSR: rd_nxt = sel_b_r;
      `GLPU_ANSR: rd_nxt = analog_r;
      `GLPU_OWSR: rd_nxt = wr_en_r;
      default: hit_nxt = 1'b0;
    endcase
  end

  // read data registered in the setup cycle so it is stable for access
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_prdata <= `GLPU_ZERO;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= hit_nxt ? rd_nxt : `GLPU_ZERO;
    end
  end

  // one strobe per write address, decoded once for all registers
  reg wr_port_set;
  reg wr_port_clr;
  reg wr_oe_set;
  reg wr_oe_clr;
  reg wr_filt_set;
  reg wr_filt_clr;
  reg wr_out_set;
  reg wr_out_clr;
  reg wr_out_word;
  reg wr_mask_set;
  reg wr_mask_clr;
  reg wr_md_set;
  reg wr_md_clr;
  reg wr_pull_off;
  reg wr_pull_on;
  reg wr_sel_a;
  reg wr_sel_b;
  reg wr_ana_set;
  reg wr_ana_clr;
  reg wr_owe_set;
  reg wr_owe_clr;
  wire rd_pend_clr;

  always @* begin
    wr_port_set = 1'b0;
    wr_port_clr = 1'b0;
    wr_oe_set = 1'b0;
    wr_oe_clr = 1'b0;
    wr_filt_set = 1'b0;
    wr_filt_clr = 1'b0;
    wr_out_set = 1'b0;
    wr_out_clr = 1'b0;
    wr_out_word = 1'b0;
    wr_mask_set = 1'b0;
    wr_mask_clr = 1'b0;
    wr_md_set = 1'b0;
    wr_md_clr = 1'b0;
    wr_pull_off = 1'b0;
    wr_pull_on = 1'b0;
    wr_sel_a = 1'b0;
    wr_sel_b = 1'b0;
    wr_ana_set = 1'b0;
    wr_ana_clr = 1'b0;
    wr_owe_set = 1'b0;
    wr_owe_clr = 1'b0;
    if (wr_acc) begin
      case (i_paddr)
        `GLPU_PER: wr_port_set = 1'b1;
        `GLPU_PDR: wr_port_clr = 1'b1;
        `GLPU_OER: wr_oe_set = 1'b1;
        `GLPU_ODR: wr_oe_clr = 1'b1;
        `GLPU_IFER: wr_filt_set = 1'b1;
        `GLPU_IFDR: wr_filt_clr = 1'b1;
        `GLPU_SODR: wr_out_set = 1'b1;
        `GLPU_CODR: wr_out_clr = 1'b1;
        `GLPU_ODSR: wr_out_word = 1'b1;
        `GLPU_IER: wr_mask_set = 1'b1;
        `GLPU_IDR: wr_mask_clr = 1'b1;
        `GLPU_MDER: wr_md_set = 1'b1;
        `GLPU_MDDR: wr_md_clr = 1'b1;
        `GLPU_PUDR: wr_pull_off = 1'b1;
        `GLPU_PUER: wr_pull_on = 1'b1;
        `GLPU_ASR: wr_sel_a = 1'b1;
        `GLPU_BSR: wr_sel_b = 1'b1;
        `GLPU_ANER: wr_ana_set = 1'b1;
        `GLPU_ANDR: wr_ana_clr = 1'b1;
        `GLPU_OWER: wr_owe_set = 1'b1;
        `GLPU_OWDR: wr_owe_clr = 1'b1;
        default: wr_port_set = 1'b0;
      endcase
    end
  end
  assign rd_pend_clr = rd_acc && (i_paddr == `GLPU_ISR);

  reg [31:0] port_en_nxt;
  reg [31:0] out_en_nxt;
  reg [31:0] filt_en_nxt;
  reg [31:0] out_data_nxt;
  reg [31:0] irq_mask_nxt;
  reg [31:0] irq_pend_nxt;
  reg [31:0] multi_drv_nxt;
  reg [31:0] pull_dis_nxt;
  reg [31:0] sel_b_nxt;
  reg [31:0] analog_nxt;
  reg [31:0] wr_en_nxt;

  always @* begin
    port_en_nxt = port_en_r;
    if (wr_port_set) begin
      port_en_nxt = port_en_r | i_pwdata;
    end else if (wr_port_clr) begin
      port_en_nxt = port_en_r & ~i_pwdata;
    end
  end

  always @* begin
    out_en_nxt = out_en_r;
    if (wr_oe_set) begin
      out_en_nxt = out_en_r | i_pwdata;
    end else if (wr_oe_clr) begin
      out_en_nxt = out_en_r & ~i_pwdata;
    end
  end

  always @* begin
    filt_en_nxt = filt_en_r;
    if (wr_filt_set) begin
      filt_en_nxt = filt_en_r | i_pwdata;
    end else if (wr_filt_clr) begin
      filt_en_nxt = filt_en_r & ~i_pwdata;
    end
  end

  always @* begin
    out_data_nxt = out_data_r;
    if (wr_out_set) begin
      out_data_nxt = out_data_r | i_pwdata;
    end else if (wr_out_clr) begin
      out_data_nxt = out_data_r & ~i_pwdata;
    end else if (wr_out_word) begin
      // whole-word write only touches lines enabled for it
      out_data_nxt = (out_data_r & ~wr_en_r) |
                     (i_pwdata & wr_en_r);
    end
  end

  always @* begin
    irq_mask_nxt = irq_mask_r;
    if (wr_mask_set) begin
      irq_mask_nxt = irq_mask_r | i_pwdata;
    end else if (wr_mask_clr) begin
      irq_mask_nxt = irq_mask_r & ~i_pwdata;
    end
  end

  // the read clears only what it returned; a change after the setup edge survives
  always @* begin
    irq_pend_nxt = irq_pend_r | changed;
    if (rd_pend_clr) begin
      irq_pend_nxt = (irq_pend_r & ~o_prdata) | changed;
    end
  end

  always @* begin
    multi_drv_nxt = multi_drv_r;
    if (wr_md_set) begin
      multi_drv_nxt = multi_drv_r | i_pwdata;
    end else if (wr_md_clr) begin
      multi_drv_nxt = multi_drv_r & ~i_pwdata;
    end
  end

  always @* begin
    pull_dis_nxt = pull_dis_r;
    if (wr_pull_off) begin
      pull_dis_nxt = pull_dis_r | i_pwdata;
    end else if (wr_pull_on) begin
      pull_dis_nxt = pull_dis_r & ~i_pwdata;
    end
  end

  always @* begin
    sel_b_nxt = sel_b_r;
    if (wr_sel_a) begin
      sel_b_nxt = sel_b_r & ~i_pwdata;
    end else if (wr_sel_b) begin
      sel_b_nxt = sel_b_r | i_pwdata;
    end
  end

  always @* begin
    analog_nxt = analog_r;
    if (wr_ana_set) begin
      analog_nxt = analog_r | i_pwdata;
    end else if (wr_ana_clr) begin
      analog_nxt = analog_r & ~i_pwdata;
    end
  end

  always @* begin
    wr_en_nxt = wr_en_r;
    if (wr_owe_set) begin
      wr_en_nxt = wr_en_r | i_pwdata;
    end else if (wr_owe_clr) begin
      wr_en_nxt = wr_en_r & ~i_pwdata;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      port_en_r <= `GLPU_ONES;
      out_en_r <= `GLPU_ZERO;
      pull_dis_r <= `GLPU_ZERO;
      filt_en_r <= `GLPU_ZERO;
      out_data_r <= `GLPU_ZERO;
      irq_mask_r <= `GLPU_ZERO;
      irq_pend_r <= `GLPU_ZERO;
      multi_drv_r <= `GLPU_ZERO;
      sel_b_r <= `GLPU_ZERO;
      analog_r <= `GLPU_ZERO;
      wr_en_r <= `GLPU_ZERO;
      last_lvl_r <= `GLPU_ONES;
    end else begin
      port_en_r <= port_en_nxt;
      out_en_r <= out_en_nxt;
      pull_dis_r <= pull_dis_nxt;
      filt_en_r <= filt_en_nxt;
      out_data_r <= out_data_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_pend_r <= irq_pend_nxt;
      multi_drv_r <= multi_drv_nxt;
      sel_b_r <= sel_b_nxt;
      analog_r <= analog_nxt;
      wr_en_r <= wr_en_nxt;
      last_lvl_r <= level;
    end
  end
endmodule

// file: tb/glpu_chk.sv
// Purpose: port assertions for the line port unit
// Assumes: probe address 8'hfc is unmapped
// Notes: judges only what the pins show
`timescale 1ns/1ns
module glpu_chk (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_irq,
  input wire [7:0] i_paddr,
  input wire [7:0] o_irq_id,
  input wire [31:0] o_prdata,
  input wire [31:0] i_pad_in,
  input wire [31:0] o_pad_oe,
  input wire [31:0] o_pad_pullup_en,
  input wire [31:0] o_pad_analog_en,
  input wire [31:0] o_periph_in
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_zero_wait:
    assert property (o_pready && !o_pslverr) else $error("slow answer");
  a_irq_ident:
    assert property (o_irq_id == 8'h02) else $error("irq id");
  a_reset_pads:
    assert property ($fell(i_sys_rst) |-> !o_pad_oe && &o_pad_pullup_en) else $error("reset pad");
  a_reset_irq:
    assert property ($fell(i_sys_rst) |-> !o_irq) else $error("reset irq");
  a_analog_free:
    assert property (!(o_pad_analog_en & o_pad_oe)) else $error("analog driven");
  a_unmapped_zero:
    assert property (i_psel && !i_penable && !i_pwrite && i_paddr == 8'hfc |=> !o_prdata)
      else $error("unmapped data");
  a_rdata_holds:
    assert property (!(i_psel && !i_penable) |=> $stable(o_prdata)) else $error("data moved");
  // waits out the filter so only a stale or lost level can fire
  a_level_sync:
    assert property ((!i_sys_rst)[*8] ##0 $stable(i_pad_in)[*6] |-> o_periph_in == i_pad_in)
      else $error("level lost");
endmodule
bind glpu_top glpu_chk glpu_chk_i (.*);

// file: tb/glpu_pads.sv
// Purpose: pad side: external drivers, pull-ups, floating lines
// Assumes: the unit's own driver wins on its line
// Notes: a floating line toggles each cycle so no stale level survives
`timescale 1ns/1ns
module glpu_pads (
  input wire i_clk_sys,
  input wire [31:0] i_out,
  input wire [31:0] i_oe,
  input wire [31:0] i_pu,
  input wire [31:0] i_ext,
  input wire [31:0] i_ext_en,
  output wire [31:0] o_pad
);
  logic [31:0] flt_r = '0;
  always @(posedge i_clk_sys) flt_r <= ~flt_r;
  assign o_pad = i_oe & i_out | ~i_oe & (i_ext_en & i_ext | ~i_ext_en & (i_pu | flt_r));
endmodule

// file: tb/tb.sv
// Purpose: self-checking bench for the line port unit
// Assumes: zero-wait APB, pads resolved by glpu_pads
// Notes: expected values come from masks kept here
`timescale 1ns/1ns
`include "glpu_consts.vh"
module tb;
  logic i_clk_sys = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, i_periph_a_out = '0, i_periph_a_oe = '0, i_periph_b_out = '0;
  logic [31:0] i_periph_b_oe = '0, ext = '0, xen = '0, r, v, w, m_oe = '0, m_d = '0;
  wire [31:0] o_prdata, i_pad_in, o_pad_out, o_pad_oe, o_pad_pullup_en, o_pad_analog_en;
  wire [31:0] o_periph_in;
  wire o_irq, o_pready, o_pslverr;
  wire [7:0] o_irq_id;
  integer seed = 32'h17de, n_mismatch = 0, comparisons = 0, k, t;
  always #5 i_clk_sys = ~i_clk_sys;
  glpu_top glpu_top_i (.*);
  glpu_pads glpu_pads_i (.i_clk_sys, .i_out(o_pad_out), .i_oe(o_pad_oe), .i_pu(o_pad_pullup_en),
    .i_ext(ext), .i_ext_en(xen), .o_pad(i_pad_in));
  task automatic cyc(input integer n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // setup, then hold until pready is seen high; one idle cycle keeps drivers apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    cyc(1);
    i_penable <= 1;
    t = 0;
    do begin
      cyc(1);
      t++;
    end while (o_pready !== 1'b1 && t < 20);
    if (o_pready !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    r = o_prdata;
    i_psel <= 0;
    i_penable <= 0;
    cyc(1);
  endtask
  initial begin
    cyc(10);
    i_sys_rst <= 0;
    cyc(1);
    apb(0, `GLPU_PSR, 0);
    chk("psr", `GLPU_ONES, r);
    apb(0, `GLPU_PUSR, 0);
    chk("pusr", '0, r);
    chk("oe", '0, o_pad_oe);
    apb(0, 8'hfc, 0);
    chk("unmapped", '0, r);
    apb(1, `GLPU_OWER, `GLPU_ONES);
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      apb(1, k[0] ? `GLPU_ODR : `GLPU_OER, v);
      m_oe = k[0] ? m_oe & ~v : m_oe | v;
      v = $random(seed);
      apb(1, k[0] ? `GLPU_CODR : `GLPU_SODR, v);
      m_d = k[0] ? m_d & ~v : m_d | v;
      apb(0, `GLPU_OSR, 0);
      chk("osr", m_oe, r);
      chk("oe", m_oe, o_pad_oe);
      chk("out", m_d & m_oe, o_pad_out & o_pad_oe);
    end
    v = $random(seed);
    apb(1, `GLPU_OWDR, v);
    apb(0, `GLPU_OWSR, 0);
    chk("owsr", ~v, r);
    w = $random(seed);
    apb(1, `GLPU_ODSR, w);
    m_d = m_d & v | w & ~v;
    chk("odsr", m_d & m_oe, o_pad_out & o_pad_oe);
    apb(0, `GLPU_ODSR, 0);
    chk("odsr rd", m_d, r);
    apb(1, `GLPU_MDER, `GLPU_ONES);
    chk("drain", m_oe & ~m_d, o_pad_oe);
    apb(0, `GLPU_MDSR, 0);
    chk("mdsr", `GLPU_ONES, r);
    apb(1, `GLPU_MDDR, `GLPU_ONES);
    v = $random(seed);
    apb(1, `GLPU_PUDR, v);
    chk("pullup", ~v, o_pad_pullup_en);
    ext <= $random(seed);
    xen <= `GLPU_ONES;
    cyc(8);
    apb(0, `GLPU_ISR, 0);
    apb(1, `GLPU_IER, `GLPU_ONES);
    apb(0, `GLPU_IMR, 0);
    chk("imr", `GLPU_ONES, r);
    apb(0, `GLPU_PDSR, 0);
    chk("pdsr", m_d & m_oe | ext & ~m_oe, r);
    chk("periph in", m_d & m_oe | ext & ~m_oe, o_periph_in);
    // second pass is masked: flags still latch, the line stays quiet
    for (k = 0; k < 2; k++) begin
      ext <= ~ext;
      cyc(8);
      chk("irq", 32'(k == 0), 32'(o_irq));
      apb(0, `GLPU_ISR, 0);
      chk("isr", ~m_oe, r);
      chk("irq", '0, 32'(o_irq));
      apb(1, `GLPU_IDR, `GLPU_ONES);
    end
    // one-cycle pulse on the free lines must not reach level or flags
    apb(1, `GLPU_IFER, `GLPU_ONES);
    apb(0, `GLPU_IFSR, 0);
    chk("ifsr", `GLPU_ONES, r);
    ext <= ~ext;
    cyc(1);
    ext <= ~ext;
    cyc(8);
    apb(0, `GLPU_ISR, 0);
    chk("glitch isr", '0, r);
    chk("glitch level", m_d & m_oe | ext & ~m_oe, o_periph_in);
    ext <= ~ext;
    cyc(8);
    chk("filtered level", m_d & m_oe | ext & ~m_oe, o_periph_in);
    apb(1, `GLPU_ANER, `GLPU_ONES);
    chk("analog", `GLPU_ONES, o_pad_analog_en);
    chk("analog oe", '0, o_pad_oe);
    apb(1, `GLPU_ANDR, `GLPU_ONES);
    i_periph_a_out <= $random(seed);
    i_periph_a_oe <= $random(seed);
    i_periph_b_out <= $random(seed);
    i_periph_b_oe <= $random(seed);
    apb(1, `GLPU_PDR, `GLPU_ONES);
    apb(1, `GLPU_BSR, 32'hffff_0000);
    v = i_periph_b_oe & 32'hffff_0000 | i_periph_a_oe & 32'h0000_ffff;
    chk("periph oe", v, o_pad_oe);
    r = i_periph_b_out & 32'hffff_0000 | i_periph_a_out & 32'h0000_ffff;
    chk("periph out", r & v, o_pad_out & o_pad_oe);
    apb(0, `GLPU_ABSR, 0);
    chk("absr", 32'hffff_0000, r);
    // second reset in mid-run brings every line back to a pulled-up input
    i_sys_rst <= 1;
    cyc(2);
    i_sys_rst <= 0;
    cyc(1);
    chk("reset oe", '0, o_pad_oe);
    apb(0, `GLPU_PSR, 0);
    chk("reset psr", `GLPU_ONES, r);
    end_of_test();
  end
endmodule
